// ==== rtl/triple_pwm.sv ====
// Three-channel 10-bit pulse width modulator with APB registers
//
// Our own choices: the register offsets and the APB interface to the registers.
`include "triple_pwm_map.svh"

module triple_pwm #(
   parameter int NCH = 3,
   parameter int CW  = 10
) (
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        instr_clock_periods_select_i,
   input  wire logic        sleep_i,
   input  wire logic        adc_running_i,
   output logic [NCH-1:0]   pulse_output_o,
   output logic             irq_o
);

   // Control registers and per-channel software values
   logic [7:0]    ctrl_a_reg, ctrl_a_next;
   logic [7:0]    ctrl_b_reg, ctrl_b_next;
   logic [7:0]    status_reg, status_next;
   logic [7:0]    mask_reg, mask_next;
   logic [CW-1:0] period_value_reg [NCH];
   logic [CW-1:0] period_value_next [NCH];
   logic [CW-1:0] duty_buffer_reg [NCH];
   logic [CW-1:0] duty_buffer_next [NCH];
   logic [31:0]   prdata_reg, prdata_next;

   // Channel datapath state
   logic [CW-1:0] period_counter_reg [NCH];
   logic [CW-1:0] period_counter_next [NCH];
   logic [CW-1:0] duty_latch_reg [NCH];
   logic [CW-1:0] duty_latch_next [NCH];
   logic [7:0]    presc_reg [NCH];
   logic [7:0]    presc_next [NCH];
   logic [NCH-1:0] pulse_reg;
   // Nets, so each channel drives its own bit
   wire logic [NCH-1:0] pulse_next;
   wire logic [NCH-1:0] per_evt;
   wire logic [NCH-1:0] cnt_evt;
   logic [1:0]    base_reg, base_next;
   logic          base_tick;
   logic          run_ok;
   triple_pwm_pkg::chan_cfg_s cfg [NCH];

   // Pin inputs pass two flip-flops before use
   logic [2:0] sync1_reg, sync2_reg;

   logic wr_en, rd_en;

   // APB: zero wait state, every access completes in its access phase
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = 1'b0;
   assign prdata_o  = prdata_reg;

   // Level synchroniser for select, sleep and conversion status
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end else begin
         sync1_reg <= {instr_clock_periods_select_i, sleep_i, adc_running_i};
         sync2_reg <= sync1_reg;
      end
   end

   // Sleep stops the counters unless a conversion keeps them alive
   assign run_ok = ~sync2_reg[1] | sync2_reg[0];

   // Base tick: two or four oscillator periods per instruction cycle
   always_comb begin
      base_next = base_reg + 2'h1;
      base_tick = 1'b0;
      if (!sync2_reg[2]) begin
         base_tick = base_reg[0];
         if (base_reg[0])
            base_next = 2'h0;
      end else begin
         base_tick = (base_reg == 2'h3);
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i)
         base_reg <= 2'h0;
      else
         base_reg <= base_next;
   end

   // Map the loose enable and prescaler fields onto each channel
   assign cfg[0] = '{ctrl_a_reg[`CTRL_A_EN1_BIT],
                     ctrl_a_reg[`CTRL_A_PWM1_BIT],
                     ctrl_a_reg[2:0]};
   assign cfg[1] = '{ctrl_b_reg[`CTRL_B_EN2_BIT],
                     ctrl_a_reg[`CTRL_A_PWM2_BIT],
                     ctrl_b_reg[6:4]};
   assign cfg[2] = '{ctrl_b_reg[`CTRL_B_EN3_BIT],
                     ctrl_a_reg[`CTRL_A_PWM3_BIT],
                     ctrl_b_reg[2:0]};

   // One datapath per channel: prescaler, counter, duty latch and output
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_chan
         logic       ptick;
         logic [7:0] pmask;
         logic       pmatch;
         logic       dmatch;
         logic       pulse_nxt;
         logic       per_hit;
         logic       cnt_hit;

         assign pulse_next[g] = pulse_nxt;
         assign per_evt[g]    = per_hit;
         assign cnt_evt[g]    = cnt_hit;

         // Select 0..7 gives divide 2..256; ticks when the low bits wrap
         assign pmask = 8'((9'h002 << cfg[g].prescale_sel)
                           - 9'h001);
         assign ptick = base_tick & run_ok & cfg[g].counter_enable
                        & ((presc_reg[g] & pmask) == pmask);
         assign pmatch = (period_counter_reg[g] == period_value_reg[g]);
         assign dmatch = (duty_latch_reg[g] == period_counter_reg[g]);

         always_comb begin
            presc_next[g]          = presc_reg[g];
            period_counter_next[g] = period_counter_reg[g];
            duty_latch_next[g]     = duty_latch_reg[g];
            pulse_nxt              = pulse_reg[g];
            per_hit                = 1'b0;
            cnt_hit                = 1'b0;
            // Disabled counters hold, so the prescaler freezes too
            if (base_tick & run_ok & cfg[g].counter_enable)
               presc_next[g] = presc_reg[g] + 8'h01;
            if (ptick) begin
               if (pmatch) begin
                  period_counter_next[g] = '0;
                  duty_latch_next[g]     = duty_buffer_reg[g];
                  per_hit                = cfg[g].pulse_enable;
                  if (cfg[g].pulse_enable) begin
                     pulse_nxt = 1'b1;
                  end
               end else begin
                  period_counter_next[g] = period_counter_reg[g]
                                           + 1'b1;
               end
            end
            // Falls once the latch meets the count; high time is duty ticks plus one clock
            if (cfg[g].pulse_enable && dmatch && pulse_reg[g]
                && !(ptick && pmatch)) begin
               pulse_nxt = 1'b0;
               cnt_hit   = 1'b1;
            end
            if (!cfg[g].pulse_enable)
               pulse_nxt = 1'b0;
         end

         always_ff @(posedge clock_i) begin
            if (reset_i) begin
               presc_reg[g]          <= 8'h00;
               period_counter_reg[g] <= '0;
               duty_latch_reg[g]     <= '0;
            end else begin
               presc_reg[g]          <= presc_next[g];
               period_counter_reg[g] <= period_counter_next[g];
               duty_latch_reg[g]     <= duty_latch_next[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_i) begin
      if (reset_i)
         pulse_reg <= '0;
      else
         pulse_reg <= pulse_next;
   end

   assign pulse_output_o = pulse_reg;

   // Register writes; hardware event sets win over a write-one clear
   always_comb begin
      ctrl_a_next       = ctrl_a_reg;
      ctrl_b_next       = ctrl_b_reg;
      mask_next         = mask_reg;
      period_value_next = period_value_reg;
      duty_buffer_next  = duty_buffer_reg;
      status_next       = status_reg;
      if (wr_en) begin
         case (paddr_i)
            `CTRL_A_OFS: ctrl_a_next = pwdata_i[7:0] & 8'hEF;
            `CTRL_B_OFS: ctrl_b_next = pwdata_i[7:0];
            `MASK_OFS:   mask_next   = pwdata_i[7:0] & 8'h77;
            `STATUS_OFS: status_next = status_reg & ~pwdata_i[7:0];
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (paddr_i == `PERIOD0_OFS + 12'(i) * `CHAN_STRIDE)
                     period_value_next[i] = pwdata_i[CW-1:0];
                  if (paddr_i == `DUTY0_OFS + 12'(i) * `CHAN_STRIDE)
                     duty_buffer_next[i] = pwdata_i[CW-1:0];
               end
            end
         endcase
      end
      status_next[`STAT_PER_LSB +: 3] = status_next[`STAT_PER_LSB +: 3]
                                       | per_evt;
      status_next[`STAT_CNT_LSB +: 3] = status_next[`STAT_CNT_LSB +: 3]
                                       | cnt_evt;
   end

   // Read mux: data captured in the setup phase, counters read-only
   always_comb begin
      prdata_next = prdata_reg;
      if (rd_en) begin
         prdata_next = 32'h0000_0000;
         case (paddr_i)
            `CTRL_A_OFS: prdata_next[7:0] = ctrl_a_reg;
            `CTRL_B_OFS: prdata_next[7:0] = ctrl_b_reg;
            `MASK_OFS:   prdata_next[7:0] = mask_reg;
            `STATUS_OFS: prdata_next[7:0] = status_reg;
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (paddr_i == `PERIOD0_OFS + 12'(i) * `CHAN_STRIDE)
                     prdata_next[CW-1:0] = period_value_reg[i];
                  if (paddr_i == `DUTY0_OFS + 12'(i) * `CHAN_STRIDE)
                     prdata_next[CW-1:0] = duty_buffer_reg[i];
                  if (paddr_i == `COUNT0_OFS + 12'(i) * `CHAN_STRIDE)
                     prdata_next[CW-1:0] = period_counter_reg[i];
                  if (paddr_i == `LATCH0_OFS + 12'(i) * `CHAN_STRIDE)
                     prdata_next[CW-1:0] = duty_latch_reg[i];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ctrl_a_reg <= `CTRL_A_RST;
         ctrl_b_reg <= `CTRL_B_RST;
         mask_reg   <= 8'h00;
         status_reg <= `STAT_RST;
         prdata_reg <= 32'h0000_0000;
         for (int i = 0; i < NCH; i++) begin
            period_value_reg[i] <= '0;
            duty_buffer_reg[i]  <= '0;
         end
      end else begin
         ctrl_a_reg       <= ctrl_a_next;
         ctrl_b_reg       <= ctrl_b_next;
         mask_reg         <= mask_next;
         status_reg       <= status_next;
         prdata_reg       <= prdata_next;
         period_value_reg <= period_value_next;
         duty_buffer_reg  <= duty_buffer_next;
      end
   end

   // Level interrupt while any unmasked flag stands
   assign irq_o = |(status_reg & mask_reg);

endmodule // triple_pwm

// ==== rtl/triple_pwm_map.svh ====
// Offsets, field positions, reset values and timing counts of the three-channel modulator
// What this block does
// - Three independent 10-bit pulse channels, each set by a period and a duty.
// - Each channel has a 10-bit up-counter behind a prescaler; read-only to software.
// - Counter enables: ch1 bit 3 of control A, ch2 bit 7 and ch3 bit 3 of control B.
// - Counter equal to period value clears on the next increment, starting a period.
// - Next increment after period match drives the pulse output high.
// - Next increment after period match copies duty buffer into duty latch.
// - Next increment after period match sets the period match flag, but only while that channel's pulse output is enabled.
// - Period is (period value + 1) ticks of base clock times prescale ratio.
// - Duty latch equal to counter drives the output low for the rest of period.
// - Duty buffer writable anytime; moves to the latch only at period restart.
// - High time equals duty value ticks times base divide times prescale ratio, plus one clock.
// - A comparator match that changes the output sets the counter match flag.
// - Prescaler select 000 divides the counter clock by 2.
// - Instruction clock select 0 makes one base tick two oscillator periods.
// - Prescaler select chooses divide by 2 to 256 and is cleared by reset.
// - Counters stop in sleep unless an analog conversion is running.
`ifndef TRIPLE_PWM_MAP_SVH
`define TRIPLE_PWM_MAP_SVH

// Control registers keep their word index; byte address is four times it
`define CTRL_A_IDX      5
`define CTRL_B_IDX      6
// Register byte offsets on the APB, one aligned word each
`define CTRL_A_OFS      12'h0014
`define CTRL_B_OFS      12'h0018
`define STATUS_OFS      12'h0010
`define MASK_OFS        12'h001C
`define PERIOD0_OFS     12'h0020
`define DUTY0_OFS       12'h0030
`define COUNT0_OFS      12'h0040
`define LATCH0_OFS      12'h0050
`define CHAN_STRIDE     12'h0004

// Field positions in the two control registers
`define CTRL_A_EN1_BIT  3
`define CTRL_A_PWM1_BIT 5
`define CTRL_A_PWM2_BIT 6
`define CTRL_A_PWM3_BIT 7
`define CTRL_B_EN2_BIT  7
`define CTRL_B_EN3_BIT  3
`define CTRL_A_RST      8'h00
`define CTRL_B_RST      8'h00

// Status layout: period flags in bits 2:0, counter flags in bits 6:4
`define STAT_PER_LSB    0
`define STAT_CNT_LSB    4
`define STAT_RST        8'h00

// Oscillator periods per base tick for each instruction clock select
`define BASE_DIV_SEL0   2
`define BASE_DIV_SEL1   4

`endif

// ==== rtl/triple_pwm_pkg.sv ====
// Types shared by the three-channel modulator
package triple_pwm_pkg;
   typedef logic [9:0] count_t;
   typedef struct packed {
      logic   counter_enable;
      logic   pulse_enable;
      logic [2:0] prescale_sel;
   } chan_cfg_s;
endpackage

// ==== bench/triple_pwm_chk.sv ====
// Port-level checks for the three-channel modulator
`include "triple_pwm_map.svh"
module triple_pwm_chk #(
   parameter int NCH = 3,
   parameter int CW  = 10
) (
   input wire logic           clock_i,
   input wire logic           reset_i,
   input wire logic           psel_i,
   input wire logic           penable_i,
   input wire logic           pwrite_i,
   input wire logic [11:0]    paddr_i,
   input wire logic [31:0]    prdata_o,
   input wire logic           pready_o,
   input wire logic           pslverr_o,
   input wire logic           sleep_i,
   input wire logic           adc_running_i,
   input wire logic [NCH-1:0] pulse_output_o,
   input wire logic           irq_o
);
   logic [2:0] nap_reg;
   logic [2:0] nap_next;
   logic       rd;
   // Cycles asleep with no conversion; saturates so it never wraps
   always_comb begin
      nap_next = nap_reg;
      if (!sleep_i || adc_running_i) begin
         nap_next = 3'h0;
      end else if (nap_reg != 3'h7) begin
         nap_next = nap_reg + 3'h1;
      end
   end
   always_ff @(posedge clock_i) begin
      nap_reg <= reset_i ? 3'h0 : nap_next;
   end
   // Read access phase, when read data must be valid
   assign rd = psel_i && penable_i && !pwrite_i;
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_ready_no_err: assert property (psel_i |-> pready_o && !pslverr_o)
      else $error("bus answer not ready or error");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset_i |=> pulse_output_o == '0 && !irq_o)
      else $error("outputs active after reset");
   a_rise_spacing: assert property ($rose(pulse_output_o[0]) |=>
      !$rose(pulse_output_o[0]) [*3])
      else $error("period shorter than one counter step");
   a_read_upper_zero: assert property (rd |-> prdata_o[31:CW] == '0)
      else $error("read data above field width");
   a_hole_reads_zero: assert property (rd && paddr_i == 12'h0100 |->
      prdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_ctrl_bit4_zero: assert property (rd && paddr_i == `CTRL_A_OFS |->
      !prdata_o[4] && prdata_o[31:8] == '0)
      else $error("control A reserved bits not zero");
   a_mask_gaps_zero: assert property (rd && paddr_i == `MASK_OFS |->
      !prdata_o[3] && !prdata_o[7])
      else $error("mask reserved bits not zero");
   a_sleep_frozen: assert property (nap_reg == 3'h7 |->
      $stable(pulse_output_o))
      else $error("output moved in sleep");
   c_pulse0: cover property ($rose(pulse_output_o[0]));
   c_pulse2: cover property ($rose(pulse_output_o[2]));
   c_irq: cover property ($rose(irq_o));
endmodule // triple_pwm_chk

bind triple_pwm triple_pwm_chk #(.NCH(NCH), .CW(CW)) i_triple_pwm_chk (
   .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .sleep_i(sleep_i), .adc_running_i(adc_running_i),
   .pulse_output_o(pulse_output_o), .irq_o(irq_o));

// ==== bench/tb_triple_pwm.sv ====
// Self-checking bench for the three-channel modulator
`include "triple_pwm_map.svh"
module tb_triple_pwm;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        clk_sel = 1'b0;
   logic        sleep = 1'b0;
   logic        adc_run = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic [2:0]  pulse;
   logic        irq;
   logic [31:0] q;
   logic [31:0] q2;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          per;
   int          hi;
   int          step;
   logic [11:0] regs [7] = '{`CTRL_A_OFS, `CTRL_B_OFS, `STATUS_OFS,
      `MASK_OFS, `PERIOD0_OFS, `COUNT0_OFS, 12'h0100};

   triple_pwm i_triple_pwm (.clock_i(clock), .reset_i(reset),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(), .instr_clock_periods_select_i(clk_sel),
      .sleep_i(sleep), .adc_running_i(adc_run), .pulse_output_o(pulse),
      .irq_o(irq));

   // 40 MHz clock
   always #12.5 clock = ~clock;

   // Watchdog: the whole run needs well under this many cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         conclude();
      end
   end

   task automatic conclude();
      if (num_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Channel set-up in the order software must follow: period, duty, enables
   task automatic cfg(input int ch, input logic [9:0] p, input logic [9:0] d,
                      input logic [2:0] s);
      xfer(1'b1, `PERIOD0_OFS + `CHAN_STRIDE * 12'(ch), 32'(p));
      xfer(1'b1, `DUTY0_OFS + `CHAN_STRIDE * 12'(ch), 32'(d));
      xfer(1'b1, `CTRL_B_OFS, ch == 1 ? {24'h00_0000, 1'h1, s, 4'h0} :
         ch == 2 ? {24'h00_0000, 5'h01, s} : 32'h0000_0000);
      xfer(1'b1, `CTRL_A_OFS, ch == 0 ? {24'h00_0000, 5'h05, s} :
         ch == 1 ? 32'h0000_0040 : 32'h0000_0080);
   endtask

   // Rise-to-rise period and high time, sampled on the falling edge
   task automatic meas(input int ch);
      @(negedge clock);
      while (pulse[ch] !== 1'b0) @(negedge clock);
      while (pulse[ch] !== 1'b1) @(negedge clock);
      hi = 0;
      while (pulse[ch] === 1'b1) begin
         @(negedge clock);
         hi++;
      end
      per = hi;
      while (pulse[ch] === 1'b0) begin
         @(negedge clock);
         per++;
      end
   endtask

   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      // Reset values, and a hole in the map reads zero
      foreach (regs[i]) begin
         xfer(1'b0, regs[i], 32'h0000_0000);
         check(q, 32'h0000_0000);
      end
      // Every prescaler code, period value 1 and duty 1
      for (int s = 0; s < 8; s++) begin
         cfg(0, 10'h001, 10'h001, 3'(s));
         meas(0);
         step = 2 << (s + 1);
         check(per, 2 * step);
         check(hi, step + 1);
      end
      // Each channel on its own enable bits; the last on the slow base tick
      xfer(1'b1, `MASK_OFS, 32'h0000_0077);
      for (int c = 0; c < 3; c++) begin
         clk_sel <= (c == 2);
         step = (c == 2) ? 8 : 4;
         cfg(c, 10'h009, 10'h003, 3'h0);
         meas(c);
         check(per, 10 * step);
         check(hi, 3 * step + 1);
         xfer(1'b1, `CTRL_A_OFS, 32'h0000_0000);
         xfer(1'b1, `CTRL_B_OFS, 32'h0000_0000);
      end
      clk_sel <= 1'b0;
      // Flags are sticky, raise the interrupt and clear on a written one
      xfer(1'b0, `STATUS_OFS, 32'h0000_0000);
      check(q, 32'h0000_0077);
      check(32'(irq), 32'h0000_0001);
      xfer(1'b1, `STATUS_OFS, 32'h0000_0077);
      xfer(1'b0, `STATUS_OFS, 32'h0000_0000);
      check(q | 32'(irq), 32'h0000_0000);
      // Masked flag still sets but keeps the interrupt low
      xfer(1'b1, `MASK_OFS, 32'h0000_0000);
      cfg(0, 10'h009, 10'h003, 3'h0);
      meas(0);
      xfer(1'b0, `STATUS_OFS, 32'h0000_0000);
      check(q[0] + 32'(irq), 32'h0000_0001);
      // New duty waits in the buffer until the period restarts
      xfer(1'b1, `DUTY0_OFS, 32'h0000_0006);
      xfer(1'b0, `LATCH0_OFS, 32'h0000_0000);
      check(q, 32'h0000_0003);
      meas(0);
      check(hi, 25);
      // Stopped counter holds and ignores writes
      xfer(1'b1, `CTRL_A_OFS, 32'h0000_0020);
      xfer(1'b0, `COUNT0_OFS, 32'h0000_0000);
      q2 = q;
      check(32'(q2 <= 32'h0000_0009), 32'h0000_0001);
      xfer(1'b1, `COUNT0_OFS, 32'h0000_0155);
      repeat (20) @(posedge clock);
      xfer(1'b0, `COUNT0_OFS, 32'h0000_0000);
      check(q, q2);
      // Sleep stops the counter unless a conversion is running
      cfg(0, 10'h3e8, 10'h003, 3'h0);
      sleep <= 1'b1;
      repeat (6) @(posedge clock);
      xfer(1'b0, `COUNT0_OFS, 32'h0000_0000);
      q2 = q;
      repeat (40) @(posedge clock);
      xfer(1'b0, `COUNT0_OFS, 32'h0000_0000);
      check(q, q2);
      adc_run <= 1'b1;
      repeat (40) @(posedge clock);
      xfer(1'b0, `COUNT0_OFS, 32'h0000_0000);
      check(32'(q != q2), 32'h0000_0001);
      conclude();
   end
endmodule // tb_triple_pwm
